// >>> hdl/eirq_pkg.sv
// Package of constants and types for the external request logic.
package eirq_pkg;
   localparam int          NUM_LINES      = 8;
   localparam int          ADDR_W         = 5;
   localparam int          DATA_W         = 32;
   // Register byte offsets.
   localparam logic [4:0]  OFS_FLAG       = 5'h00;
   localparam logic [4:0]  OFS_PIN_SEL    = 5'h04;
   localparam logic [4:0]  OFS_WAKE       = 5'h08;
   localparam logic [4:0]  OFS_SENSE      = 5'h0C;
   localparam logic [4:0]  OFS_ENABLE     = 5'h10;
   localparam logic [4:0]  OFS_PRIO_A     = 5'h14;
   localparam logic [4:0]  OFS_PRIO_B     = 5'h18;
   localparam logic [4:0]  OFS_CTRL       = 5'h1C;
   // Reset values.
   localparam logic [7:0]  RST_FLAG       = 8'h00;
   localparam logic [7:0]  RST_PIN_SEL    = 8'h00;
   localparam logic [7:0]  RST_WAKE       = 8'h07;
   localparam logic [15:0] RST_SENSE      = 16'h0000;
   localparam logic [7:0]  RST_ENABLE     = 8'h00;
   localparam logic [15:0] RST_PRIO       = 16'h7777;
   // Field positions and widths.
   localparam int          CTRL_NMI_EDGE  = 3;
   localparam int          PRIO_W         = 3;
   localparam int          PRIO_STEP      = 4;
   // Sense-control encodings.
   localparam logic [1:0]  SENSE_LOW      = 2'h0;
   localparam logic [1:0]  SENSE_FALL     = 2'h1;
   localparam logic [1:0]  SENSE_RISE     = 2'h2;
   localparam logic [1:0]  SENSE_BOTH     = 2'h3;
   // Oscillator settling time and its cycle count (rounded up).
   localparam int          CLK_MHZ        = 200;
   localparam int          OSC_SETTLE_NS  = 10000;
   localparam int          SETTLE_CYC     =
      (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic                read;
      logic                write;
      logic [ADDR_W-1:0]   address;
      logic [DATA_W-1:0]   writedata;
      logic [3:0]          byteenable;
   } eirq_bus_req_t;

   typedef struct packed {
      logic                take;
      logic [2:0]          line;
   } eirq_line_evt_t;
endpackage

// >>> hdl/eirq_ctrl.sv
// External request logic: eight maskable lines and one nonmaskable line.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module eirq_ctrl #(
   parameter int SETTLE_CYCLES = eirq_pkg::SETTLE_CYC
) (
   input  wire  logic                      core_clk,
   input  wire  logic                      resetn,
   input  wire  eirq_pkg::eirq_bus_req_t   avs_req,
   output logic [eirq_pkg::DATA_W-1:0]     avs_readdata,
   output logic                            avs_waitrequest,
   input  wire  logic [7:0]                primary_pin,
   input  wire  logic [7:0]                port4_pin,
   input  wire  logic                      nmi_pin,
   input  wire  logic                      standby,
   input  wire  eirq_pkg::eirq_line_evt_t  exc_evt,
   input  wire  eirq_pkg::eirq_line_evt_t  xfer_evt,
   input  wire  logic                      xfer_disable_sel,
   output logic [7:0]                      irq_req,
   output logic [23:0]                     irq_priority,
   output logic                            nmi_req,
   output logic                            standby_exit
);
   import eirq_pkg::*;

   localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYCLES - 1);

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [4:0]        ofs);
      hit = (a[4:2] == ofs[4:2]);
   endfunction

   logic [7:0]  line_request_flag;
   logic [7:0]  line_pin_choice;
   logic [7:0]  line_wake_enable;
   logic [15:0] sense_control_low;
   logic [7:0]  line_enable_register;
   logic [15:0] prio_a;
   logic [15:0] prio_b;
   logic        nonmaskable_edge_select;
   logic [7:0]  clear_armed, sw_clear;
   logic [7:0]  pri_s1, pri_s2, alt_s1, alt_s2;
   logic        nmi_s1, nmi_s2, nmi_prev;
   logic [7:0]  sel_prev, sel_now, detect, hw_clear;
   logic        nmi_edge, settling;
   logic [11:0] settle_cnt, wake_age;
   logic        acc_done, wr_done, rd_done;
   logic [DATA_W-1:0] next_readdata;
   logic [PRIO_W-1:0] irq_prio_w [NUM_LINES];

   // Bus slave: one wait state, request completes on the edge where
   // waitrequest is sampled low.
   assign acc_done = (avs_req.read | avs_req.write) & ~avs_waitrequest;
   assign wr_done  = acc_done & avs_req.write;
   assign rd_done  = acc_done & avs_req.read;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_req.read | avs_req.write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      next_readdata = '0;
      if (hit(avs_req.address, OFS_FLAG)) begin
         next_readdata[7:0] = line_request_flag;
      end else if (hit(avs_req.address, OFS_PIN_SEL)) begin
         next_readdata[7:0] = line_pin_choice;
      end else if (hit(avs_req.address, OFS_WAKE)) begin
         next_readdata[7:0] = line_wake_enable;
      end else if (hit(avs_req.address, OFS_SENSE)) begin
         next_readdata[15:0] = sense_control_low;
      end else if (hit(avs_req.address, OFS_ENABLE)) begin
         next_readdata[7:0] = line_enable_register;
      end else if (hit(avs_req.address, OFS_PRIO_A)) begin
         next_readdata[15:0] = prio_a;
      end else if (hit(avs_req.address, OFS_PRIO_B)) begin
         next_readdata[15:0] = prio_b;
      end else if (hit(avs_req.address, OFS_CTRL)) begin
         next_readdata[CTRL_NMI_EDGE] = nonmaskable_edge_select;
      end
   end

   // Read data is loaded with the wait state, so it stands at completion.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= '0;
      end else if (avs_req.read & avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   // Plain control registers; writes to bytes above each register's width are discarded.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         line_pin_choice         <= RST_PIN_SEL;
         line_wake_enable        <= RST_WAKE;
         sense_control_low       <= RST_SENSE;
         line_enable_register    <= RST_ENABLE;
         prio_a                  <= RST_PRIO;
         prio_b                  <= RST_PRIO;
         nonmaskable_edge_select <= 1'b0;
      end else if (wr_done) begin
         if (avs_req.byteenable[0]) begin
            if (hit(avs_req.address, OFS_PIN_SEL))
               line_pin_choice <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_WAKE))
               line_wake_enable <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_ENABLE))
               line_enable_register <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_SENSE))
               sense_control_low[7:0] <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_PRIO_A))
               prio_a[7:0] <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_PRIO_B))
               prio_b[7:0] <= avs_req.writedata[7:0];
            if (hit(avs_req.address, OFS_CTRL))
               nonmaskable_edge_select <=
                  avs_req.writedata[CTRL_NMI_EDGE];
         end
         if (avs_req.byteenable[1]) begin
            if (hit(avs_req.address, OFS_SENSE))
               sense_control_low[15:8] <= avs_req.writedata[15:8];
            if (hit(avs_req.address, OFS_PRIO_A))
               prio_a[15:8] <= avs_req.writedata[15:8];
            if (hit(avs_req.address, OFS_PRIO_B))
               prio_b[15:8] <= avs_req.writedata[15:8];
         end
      end
   end

   // Both candidates are synchronised, so the choice steers clean levels.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pri_s1 <= 8'hFF;
         pri_s2 <= 8'hFF;
         alt_s1 <= 8'hFF;
         alt_s2 <= 8'hFF;
         nmi_s1 <= 1'b1;
         nmi_s2 <= 1'b1;
         nmi_prev <= 1'b1;
         sel_prev <= 8'hFF;
      end else begin
         pri_s1 <= primary_pin;
         pri_s2 <= pri_s1;
         alt_s1 <= port4_pin;
         alt_s2 <= alt_s1;
         nmi_s1 <= nmi_pin;
         nmi_s2 <= nmi_s1;
         nmi_prev <= nmi_s2;
         sel_prev <= sel_now;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
         logic [1:0] sense;
         logic       cond;
         assign sense = sense_control_low[2*gi+1 -: 2];
         assign sel_now[gi] = line_pin_choice[gi] ? alt_s2[gi]
                                                   : pri_s2[gi];
         always_comb begin
            case (sense)
               SENSE_LOW:  cond = ~sel_now[gi];
               SENSE_FALL: cond = sel_prev[gi] & ~sel_now[gi];
               SENSE_RISE: cond = ~sel_prev[gi] & sel_now[gi];
               SENSE_BOTH: cond = sel_prev[gi] ^ sel_now[gi];
               default:    cond = 1'b0;
            endcase
         end
         // Standby gates sampling unless the line may wake.
         assign detect[gi] = cond & (~standby | line_wake_enable[gi]);
         assign hw_clear[gi] =
            (exc_evt.take & (exc_evt.line == 3'(gi)) &
             ((sense != SENSE_LOW) | sel_now[gi])) |
            (xfer_evt.take & (xfer_evt.line == 3'(gi)) &
             ~xfer_disable_sel);
         assign irq_prio_w[gi] = (gi < 4) ?
            prio_a[15 - PRIO_STEP*gi - 1 -: PRIO_W] :
            prio_b[15 - PRIO_STEP*(gi-4) - 1 -: PRIO_W];
      end
   endgenerate

   // Only a 0 written over a bit that was read as 1 clears it.
   assign sw_clear = (wr_done & avs_req.byteenable[0] &
                      hit(avs_req.address, OFS_FLAG)) ?
                     (clear_armed & ~avs_req.writedata[7:0]) : 8'h00;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clear_armed <= 8'h00;
      end else if (rd_done & hit(avs_req.address, OFS_FLAG)) begin
         clear_armed <= clear_armed | avs_readdata[7:0];
      end else if (wr_done & hit(avs_req.address, OFS_FLAG)) begin
         clear_armed <= 8'h00;
      end
   end

   // A detection in the clearing cycle wins, so no event is lost.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         line_request_flag <= RST_FLAG;
      end else begin
         line_request_flag <= detect |
            (line_request_flag & ~(sw_clear | hw_clear));
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_req      <= 8'h00;
         irq_priority <= '0;
      end else begin
         irq_req <= line_request_flag & line_enable_register;
         for (int i = 0; i < NUM_LINES; i++) begin
            irq_priority[PRIO_W*i +: PRIO_W] <= irq_prio_w[i];
         end
      end
   end

   // Nonmaskable edge: 1 selects rising, 0 falling; never gated.
   assign nmi_edge = nonmaskable_edge_select ? (~nmi_prev & nmi_s2)
                                             : (nmi_prev & ~nmi_s2);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         nmi_req <= 1'b0;
      end else begin
         nmi_req <= nmi_edge;
      end
   end

   // Wake: settling counter starts on the first qualifying request and
   // is abandoned if standby is left by other means.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         settling     <= 1'b0;
         settle_cnt   <= '0;
         standby_exit <= 1'b0;
      end else begin
         standby_exit <= 1'b0;
         if (!standby) begin
            settling   <= 1'b0;
            settle_cnt <= '0;
         end else if (settling) begin
            if (settle_cnt == SETTLE_LAST) begin
               settling     <= 1'b0;
               standby_exit <= 1'b1;
            end else begin
               settle_cnt <= settle_cnt + 12'h001;
            end
         end else if ((|detect) | nmi_edge) begin
            settling   <= 1'b1;
            settle_cnt <= '0;
         end
      end
   end

   // Edges since the wake request, kept apart from the settling counter.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wake_age <= '0;
      end else if (standby & (wake_age != 12'h000) & ~standby_exit) begin
         wake_age <= wake_age + 12'h001;
      end else begin
         wake_age <= {11'h000, standby & ((|detect) | nmi_edge)};
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence flag_read_s(int n);
      rd_done & hit(avs_req.address, OFS_FLAG) & avs_readdata[n];
   endsequence

   flag_set_a: assert property (detect[0] |=> line_request_flag[0])
      else $error("flag 0 not set after detection");
   write_one_a: assert property (wr_done & hit(avs_req.address, OFS_FLAG)
         & avs_req.writedata[3] & line_request_flag[3]
         |=> line_request_flag[3])
      else $error("writing one cleared flag 3");
   no_arm_clr_a: assert property (wr_done & ~clear_armed[3] &
         line_request_flag[3] & ~hw_clear[3] |=> line_request_flag[3])
      else $error("flag 3 cleared without prior read");
   rd_clr_a: assert property (flag_read_s(3) ##[2:8] (wr_done &
         hit(avs_req.address, OFS_FLAG) & ~avs_req.writedata[3] &
         avs_req.byteenable[0] & ~detect[3]) |=> ~line_request_flag[3])
      else $error("read then write zero did not clear flag 3");
   edge_exc_a: assert property (exc_evt.take & (exc_evt.line == 3'h2) &
         (sense_control_low[5:4] != SENSE_LOW) & ~detect[2]
         |=> ~line_request_flag[2])
      else $error("edge line 2 not cleared by handling");
   xfer_clr_a: assert property (xfer_evt.take & (xfer_evt.line == 3'h2) &
         ~xfer_disable_sel & ~detect[2] |=> ~line_request_flag[2])
      else $error("transfer start did not clear flag 2");
   stby_mask_a: assert property (standby & ~line_wake_enable[5] |->
         ~detect[5])
      else $error("line 5 sampled in standby while not wake enabled");
   req_gate_a: assert property (##1 irq_req ==
         $past(line_request_flag & line_enable_register))
      else $error("request is not flag and enable");
   nmi_pass_a: assert property (nmi_edge |=> nmi_req)
      else $error("nonmaskable edge not passed on");
   wake_time_a: assert property (standby_exit |->
         wake_age == 12'(SETTLE_CYCLES + 1))
      else $error("standby left other than after settling time");
   bus_wait_a: assert property ((avs_req.read | avs_req.write) &
         avs_waitrequest |=> ~avs_waitrequest)
      else $error("slave did not answer after one wait state");
endmodule

// >>> tb/eirq_src.sv
// Model of the external sources on the request pins and the nonmaskable pin.
`timescale 1ns/1ps
module eirq_src (
   output logic [7:0] primary_pin,
   output logic [7:0] port4_pin,
   output logic       nmi_pin
);
   // Pins idle high like a pulled-up line, so an idle source makes no edge.
   initial begin
      primary_pin = 8'hFF;
      port4_pin   = 8'hFF;
      nmi_pin     = 1'b1;
   end

   // A level source keeps its pin low until the handler lets it go.
   task automatic drive(input int alt, input int n, input logic v);
      if (alt != 0) port4_pin[n] <= v;
      else primary_pin[n] <= v;
   endtask

   task automatic drive_nmi(input logic v);
      nmi_pin <= v;
   endtask
endmodule

// >>> tb/test_eirq_ctrl.sv
// Self-checking testbench for the external request logic.
`timescale 1ns/1ps
module test_eirq_ctrl;
   import eirq_pkg::*;
   // Short settling count keeps each wake-up test to a few dozen cycles.
   localparam int SETTLE = 4;
   logic                core_clk         = 1'b0;
   logic                resetn           = 1'b0;
   eirq_bus_req_t       avs_req          = '0;
   logic [DATA_W-1:0]   avs_readdata;
   logic                avs_waitrequest;
   logic [7:0]          primary_pin;
   logic [7:0]          port4_pin;
   logic                nmi_pin;
   logic                standby          = 1'b0;
   eirq_line_evt_t      exc_evt          = '0;
   eirq_line_evt_t      xfer_evt         = '0;
   logic                xfer_disable_sel = 1'b0;
   logic [7:0]          irq_req;
   logic [23:0]         irq_priority;
   logic                nmi_req;
   logic                standby_exit;
   int                  errors           = 0;
   int                  cmp_count        = 0;
   logic [31:0]         rd;

   always #2.5 core_clk = ~core_clk;

   eirq_src i_eirq_src (
      .primary_pin (primary_pin),
      .port4_pin   (port4_pin),
      .nmi_pin     (nmi_pin)
   );

   eirq_ctrl #(.SETTLE_CYCLES(SETTLE)) i_eirq_ctrl (
      .core_clk         (core_clk),
      .resetn           (resetn),
      .avs_req          (avs_req),
      .avs_readdata     (avs_readdata),
      .avs_waitrequest  (avs_waitrequest),
      .primary_pin      (primary_pin),
      .port4_pin        (port4_pin),
      .nmi_pin          (nmi_pin),
      .standby          (standby),
      .exc_evt          (exc_evt),
      .xfer_evt         (xfer_evt),
      .xfer_disable_sel (xfer_disable_sel),
      .irq_req          (irq_req),
      .irq_priority     (irq_priority),
      .nmi_req          (nmi_req),
      .standby_exit     (standby_exit)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d,
                   byteenable: 4'hF};
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_req <= '0;
   endtask

   task automatic expect_rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask

   // Writing the complement also writes 1 over every flag that was clear, which leaves it clear.
   task automatic clear();
      bus(1'b0, OFS_FLAG, 32'h0);
      bus(1'b1, OFS_FLAG, {24'h0, ~rd[7:0]});
   endtask

   // Moves one pin (alt 2 is the nonmaskable pin), counts output pulses.
   task automatic pin(input int alt, input int n, input logic v,
                      input bit nmi, output int c);
      @(posedge core_clk);
      if (alt == 2) i_eirq_src.drive_nmi(v);
      else i_eirq_src.drive(alt, n, v);
      c = 0;
      repeat (20) begin
         @(posedge core_clk);
         if ((nmi ? nmi_req : standby_exit) === 1'b1) c++;
      end
   endtask

   task automatic evt(input bit xfer, input logic [2:0] n);
      @(posedge core_clk);
      if (xfer) xfer_evt <= '{take: 1'b1, line: n};
      else exc_evt <= '{take: 1'b1, line: n};
      @(posedge core_clk);
      exc_evt  <= '0;
      xfer_evt <= '0;
   endtask

   task automatic t_reset();
      logic [4:0]  ofs [8] = '{OFS_FLAG, OFS_PIN_SEL, OFS_WAKE, OFS_SENSE,
                              OFS_ENABLE, OFS_PRIO_A, OFS_PRIO_B, OFS_CTRL};
      logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0007, 16'h0000,
                              16'h0000, 16'h7777, 16'h7777, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         expect_rd(ofs[i], {16'h0, exp[i]});
      end
      check(32'(irq_req), 32'h0);
      bus(1'b1, OFS_PRIO_A, 32'h5360);
      bus(1'b1, OFS_PRIO_B, 32'h1234);
      repeat (2) @(posedge core_clk);
      check(32'(irq_priority[11:0]), {20'h0, 3'h0, 3'h6, 3'h3, 3'h5});
      check(32'(irq_priority[23:12]), {20'h0, 3'h4, 3'h3, 3'h2, 3'h1});
      $display("test reset done");
   endtask

   task automatic t_sense();
      logic [3:0] a_exp = 4'b1011;
      logic [3:0] b_exp = 4'b0001;
      logic [3:0] c_exp = 4'b1101;
      int         c;
      bus(1'b1, OFS_ENABLE, 32'h20);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, OFS_SENSE, 32'(m) << 10);
         pin(0, 5, 1'b0, 1'b0, c);
         expect_rd(OFS_FLAG, 32'(a_exp[m]) << 5);
         check(32'(irq_req), 32'(a_exp[m]) << 5);
         clear();
         expect_rd(OFS_FLAG, 32'(b_exp[m]) << 5);
         pin(0, 5, 1'b1, 1'b0, c);
         expect_rd(OFS_FLAG, 32'(c_exp[m]) << 5);
         clear();
         expect_rd(OFS_FLAG, 32'h0);
      end
      $display("test sense done");
   endtask

   task automatic t_clear();
      int c;
      bus(1'b1, OFS_PIN_SEL, 32'h08);
      bus(1'b1, OFS_SENSE, 32'h40);
      bus(1'b1, OFS_ENABLE, 32'h0);
      pin(0, 3, 1'b0, 1'b0, c);
      expect_rd(OFS_FLAG, 32'h0);
      pin(1, 3, 1'b0, 1'b0, c);
      check(32'(irq_req), 32'h0);
      bus(1'b1, OFS_FLAG, 32'h0);
      expect_rd(OFS_FLAG, 32'h08);
      bus(1'b1, OFS_FLAG, 32'hFF);
      expect_rd(OFS_FLAG, 32'h08);
      clear();
      bus(1'b1, OFS_FLAG, 32'hFF);
      expect_rd(OFS_FLAG, 32'h0);
      pin(0, 3, 1'b1, 1'b0, c);
      pin(1, 3, 1'b1, 1'b0, c);
      bus(1'b1, OFS_PIN_SEL, 32'h0);
      $display("test clear done");
   endtask

   task automatic t_events();
      int c;
      bus(1'b1, OFS_SENSE, 32'h10);
      pin(0, 2, 1'b0, 1'b0, c);
      evt(1'b0, 3'd1);
      expect_rd(OFS_FLAG, 32'h04);
      evt(1'b0, 3'd2);
      expect_rd(OFS_FLAG, 32'h0);
      pin(0, 2, 1'b1, 1'b0, c);
      pin(0, 2, 1'b0, 1'b0, c);
      xfer_disable_sel <= 1'b1;
      evt(1'b1, 3'd2);
      expect_rd(OFS_FLAG, 32'h04);
      xfer_disable_sel <= 1'b0;
      evt(1'b1, 3'd2);
      expect_rd(OFS_FLAG, 32'h0);
      pin(0, 2, 1'b1, 1'b0, c);
      pin(0, 4, 1'b0, 1'b0, c);
      evt(1'b0, 3'd4);
      expect_rd(OFS_FLAG, 32'h10);
      pin(0, 4, 1'b1, 1'b0, c);
      expect_rd(OFS_FLAG, 32'h10);
      evt(1'b0, 3'd4);
      expect_rd(OFS_FLAG, 32'h0);
      $display("test events done");
   endtask

   task automatic t_nmi();
      int c;
      pin(2, 0, 1'b0, 1'b1, c);
      check(32'(c), 32'd1);
      pin(2, 0, 1'b1, 1'b1, c);
      check(32'(c), 32'd0);
      bus(1'b1, OFS_CTRL, 32'h8);
      pin(2, 0, 1'b0, 1'b1, c);
      check(32'(c), 32'd0);
      pin(2, 0, 1'b1, 1'b1, c);
      check(32'(c), 32'd1);
      $display("test nmi done");
   endtask

   task automatic t_wake();
      int c;
      bus(1'b1, OFS_SENSE, 32'h401);
      pin(2, 0, 1'b0, 1'b0, c);
      standby <= 1'b1;
      pin(0, 5, 1'b0, 1'b0, c);
      check(32'(c), 32'd0);
      pin(0, 0, 1'b0, 1'b0, c);
      check(32'(c), 32'd1);
      standby <= 1'b0;
      pin(0, 0, 1'b1, 1'b0, c);
      pin(0, 5, 1'b1, 1'b0, c);
      standby <= 1'b1;
      pin(2, 0, 1'b1, 1'b0, c);
      check(32'(c), 32'd1);
      standby <= 1'b0;
      bus(1'b1, OFS_WAKE, 32'h20);
      standby <= 1'b1;
      pin(0, 5, 1'b0, 1'b0, c);
      check(32'(c), 32'd1);
      standby <= 1'b0;
      $display("test wake done");
   endtask

   initial begin
      #50000;
      errors++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_sense();
      t_clear();
      t_events();
      t_nmi();
      t_wake();
      give_verdict();
   end
endmodule
